/* File: verilog/acs_seq.sv */
`timescale 1ns/1ps

// What this block does
// - conversion lasts at least twelve bit periods
// - clock select picks 2, 8, 32 or RC
// - RC bit period typically 4 us, 2-6 allowed
// - two bit periods hold-off after completion, disconnected
// - clearing go aborts, result bytes unchanged
// - after abort wait two periods, reacquire
// - first segment between one instruction cycle and period
// - result justified into pair, unused bits zero
// - result bytes plain registers while converter off
// - RC clock adds no instruction cycle; first segment is one RC period
// - sleep completion clears go, loads, may wake
// - no interrupt enable: power down, on stays
// - sleep with non-RC clock aborts, powers down
// - analog pins read zero on port read
// - conversion ignores pin direction and configuration
// - load, go clear, flag set together
// - channel select codes 0 to 7 directly
module acs_seq
  import acs_pkg::*;
#(
  parameter int RC_NS = RC_TAD_NS,
  parameter int TW    = 8
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // register port
  input  wire acs_req_s   req,
  output logic [7:0]      rdata,
  // device state
  input  wire logic       sleep,
  input  wire logic       irq_enable,
  input  wire logic [7:0] port_pins,
  output logic            wake,
  output logic            done_flag,
  // analog side
  input  wire logic       cmp_high,
  output logic [9:0]      trial,
  output logic [2:0]      channel_select,
  output logic            hold_connect,
  output logic            analog_powered
);

  // ***************************************************************
  // bit period lengths in clocks
  // ***************************************************************
  localparam int RC_CYC_I = (RC_NS / CLK_NS < 1) ? 1 : RC_NS / CLK_NS;
  localparam logic [TW-1:0] P_DIV2  = TW'(DIV2_CYC);
  localparam logic [TW-1:0] P_DIV8  = TW'(DIV8_CYC);
  localparam logic [TW-1:0] P_DIV32 = TW'(DIV32_CYC);
  localparam logic [TW-1:0] P_RC    = TW'(RC_CYC_I);
  localparam logic [3:0] CONV_LAST  = 4'(CONV_TADS - 1);
  localparam logic [3:0] HOLD_LAST  = 4'(HOLDOFF_TADS - 1);
  localparam logic [2:0] FIRST_LAST = 3'(TCY_CYC - 1);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [1:0]    conv_clock_select;
  logic          go;
  logic          converter_on;
  logic          result_format_select;
  logic [7:0]    result_high_byte;
  logic [7:0]    result_low_byte;
  logic [7:0]    analog_mask;
  acs_state_e    state;
  acs_state_e    next_state;
  logic [3:0]    tad_cnt;
  logic [2:0]    first_cnt;
  logic [TW-1:0] period;
  logic          tick;
  logic          timed;
  logic          sleep_abort;
  logic          sw_abort;
  logic          conv_done;
  logic [9:0]    final_result;
  logic [3:0]    bit_idx;
  logic          wr_ctrl0;

  assign wr_ctrl0 = req.wr && (req.addr == ADDR_CTRL0);

  // ***************************************************************
  // bit period source
  // ***************************************************************
  // bit period chosen from the select code
  always_comb begin
    case (conv_clock_select)
      CLK_DIV2:  period = P_DIV2;
      CLK_DIV8:  period = P_DIV8;
      CLK_DIV32: period = P_DIV32;
      default:   period = P_RC; // RC period is a parameter, 2-6 us legal
    endcase
  end

  // ticks only run inside timed segments; a state change restarts them
  assign timed = (state == next_state) &&
                 (state == ST_FIRST || state == ST_CONV || state == ST_HOLDOFF);

  acs_tick #(
    .TW (TW)
  ) u_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .run     (timed),
    .period  (period),
    .tick    (tick)
  );

  // ***************************************************************
  // events
  // ***************************************************************
  // sleep with a non-RC clock kills the conversion
  assign sleep_abort = sleep && (conv_clock_select != CLK_RC) &&
                       (state == ST_FIRST || state == ST_CONV);
  // software cleared go mid conversion
  assign sw_abort    = !go && (state == ST_FIRST || state == ST_CONV);
  assign conv_done   = (state == ST_CONV) && go && !sleep_abort &&
                       tick && (tad_cnt == CONV_LAST);
  // last decision taken straight from the comparator
  assign final_result = {trial[9:1], cmp_high};

  // ***************************************************************
  // sequencer
  // ***************************************************************
  // next state; converter off overrides everything
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (converter_on) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (go) begin
          next_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (sleep_abort) begin
          next_state = ST_PDOWN;
        end else if (sw_abort) begin
          next_state = ST_HOLDOFF;
        end else if (tick && first_cnt >= FIRST_LAST) begin
          next_state = ST_CONV; // one instruction cycle then next edge
        end
      end
      ST_CONV: begin
        if (sleep_abort) begin
          next_state = ST_PDOWN;
        end else if (sw_abort) begin
          next_state = ST_HOLDOFF;
        end else if (conv_done) begin
          // asleep without interrupt enable: module off, on bit kept
          next_state = (sleep && !irq_enable) ? ST_PDOWN : ST_HOLDOFF;
        end
      end
      ST_HOLDOFF: begin
        if (tick && tad_cnt == HOLD_LAST) begin
          next_state = ST_ACQ; // acquisition restarts by itself
        end
      end
      ST_PDOWN: begin
        if (!sleep) begin
          next_state = ST_ACQ;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (!converter_on) begin
      next_state = ST_OFF;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // bit period counter within a segment
  always_ff @(posedge mclk) begin
    if (sys_rst || state != next_state) begin
      tad_cnt <= '0;
    end else if (tick) begin
      tad_cnt <= tad_cnt + 4'h1;
    end
  end

  // first segment is never shorter than one instruction cycle
  always_ff @(posedge mclk) begin
    if (sys_rst || state != ST_FIRST) begin
      first_cnt <= '0;
    end else if (first_cnt < FIRST_LAST) begin
      first_cnt <= first_cnt + 3'h1;
    end
  end

  // ***************************************************************
  // successive approximation
  // ***************************************************************
  // bit under test in periods two to eleven
  assign bit_idx = 4'(RES_BITS) - tad_cnt;

  // msb first, one bit per period; period one only loads the msb trial
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trial <= '0;
    end else if (state == ST_CONV && tick) begin
      if (tad_cnt == 4'h0) begin
        trial <= SAR_MSB;
      end else begin
        trial[bit_idx] <= cmp_high;
        if (bit_idx != 4'h0) begin
          trial[bit_idx - 4'h1] <= 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  // clock select, on bit, channel and format are plain software bits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conv_clock_select    <= CLK_DIV2;
      converter_on         <= 1'b0;
      channel_select       <= '0;
      result_format_select <= 1'b0;
      analog_mask          <= BYTE_ZERO;
    end else begin
      if (wr_ctrl0) begin
        conv_clock_select <= req.wdata[CTRL0_CLK_HI:CTRL0_CLK_LO];
        converter_on      <= req.wdata[CTRL0_ON];
        // channel driven regardless of pin direction
        channel_select    <= req.wdata[CTRL0_CHAN_HI:CTRL0_CHAN_LO];
      end
      if (req.wr && req.addr == ADDR_CTRL1) begin
        result_format_select <= req.wdata[CTRL1_FMT];
      end
      if (req.wr && req.addr == ADDR_AMASK) begin
        analog_mask <= req.wdata;
      end
    end
  end

  // go/busy: set only with converter already on, cleared by hardware
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      go <= 1'b0;
    end else if (conv_done || sleep_abort || !converter_on) begin
      go <= 1'b0;
    end else if (wr_ctrl0) begin
      go <= req.wdata[CTRL0_GO] && converter_on;
    end
  end

  // done flag: hardware set beats a software write-one clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_flag <= 1'b0;
    end else if (conv_done) begin
      done_flag <= 1'b1;
    end else if (req.wr && req.addr == ADDR_STATUS && req.wdata[STATUS_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  // ***************************************************************
  // result pair
  // ***************************************************************
  // loaded on completion or by writes while off; aborts leave it untouched
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result_high_byte <= BYTE_ZERO;
      result_low_byte  <= BYTE_ZERO;
    end else if (conv_done) begin
      if (result_format_select) begin
        result_high_byte <= {PAD_ZERO, final_result[9:8]};
        result_low_byte  <= final_result[7:0];
      end else begin
        result_high_byte <= final_result[9:2];
        result_low_byte  <= {final_result[1:0], PAD_ZERO};
      end
    end else if (req.wr && !converter_on) begin
      // general purpose bytes while the converter is off
      if (req.addr == ADDR_RES_HIGH) begin
        result_high_byte <= req.wdata;
      end
      if (req.addr == ADDR_RES_LOW) begin
        result_low_byte <= req.wdata;
      end
    end
  end

  // ***************************************************************
  // read port and analog outputs
  // ***************************************************************
  // read data stand the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (sys_rst || !req.rd) begin
      rdata <= BYTE_ZERO;
    end else begin
      case (req.addr)
        ADDR_CTRL0:    rdata <= {conv_clock_select, channel_select, go, 1'b0,
                                 converter_on};
        ADDR_CTRL1:    rdata <= {result_format_select, 7'h00};
        ADDR_RES_HIGH: rdata <= result_high_byte;
        ADDR_RES_LOW:  rdata <= result_low_byte;
        ADDR_STATUS:   rdata <= {7'h00, done_flag};
        ADDR_PORT:     rdata <= port_pins & ~analog_mask;
        ADDR_AMASK:    rdata <= analog_mask;
        default:       rdata <= BYTE_ZERO;
      endcase
    end
  end

  // analog controls follow the next state so they match the state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_connect   <= 1'b0;
      analog_powered <= 1'b0;
      wake           <= 1'b0;
    end else begin
      hold_connect   <= (next_state == ST_ACQ); // open in hold-off
      analog_powered <= (next_state != ST_OFF) && (next_state != ST_PDOWN);
      wake           <= conv_done && sleep && irq_enable;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence conv_abort_s;
    state == ST_CONV && !go && !sleep_abort;
  endsequence

  sequence settle_s;
    state == ST_HOLDOFF && !hold_connect;
  endsequence

  done_load_a: assert property (conv_done |=> !go && done_flag)
    else $error("completion did not clear go and set flag");
  go_off_a: assert property (wr_ctrl0 && !converter_on |=> !go)
    else $error("go set while converter off");
  abort_keep_a: assert property (conv_abort_s |=> $stable(result_high_byte)
    && $stable(result_low_byte) && state == ST_HOLDOFF)
    else $error("abort changed result");
  holdoff_open_a: assert property (conv_done && !sleep |=> settle_s)
    else $error("hold capacitor connected after completion");
  first_min_a: assert property (state == ST_CONV && $past(state) == ST_FIRST
    |-> $past(first_cnt) >= FIRST_LAST)
    else $error("first segment too short");
  right_just_a: assert property (conv_done && result_format_select
    |=> result_high_byte[7:2] == PAD_ZERO)
    else $error("right justified pad not zero");
  left_just_a: assert property (conv_done && !result_format_select
    |=> result_low_byte[5:0] == PAD_ZERO)
    else $error("left justified pad not zero");
  port_mask_a: assert property (req.rd && req.addr == ADDR_PORT
    |=> (rdata & analog_mask) == BYTE_ZERO)
    else $error("analog pin read nonzero");
  sleep_abort_a: assert property (sleep_abort && converter_on
    |=> state == ST_PDOWN && converter_on && !go)
    else $error("sleep abort failed");
  sleep_off_a: assert property (conv_done && sleep && !irq_enable
    |=> state == ST_PDOWN && converter_on ##1 !analog_powered)
    else $error("no power down after sleep completion");

endmodule

/* File: verilog/acs_pkg.sv */
package acs_pkg;

  // ***************************************************************
  // register map (word index on the plain register port)
  // ***************************************************************
  localparam logic [2:0] ADDR_CTRL0    = 3'h0;
  localparam logic [2:0] ADDR_CTRL1    = 3'h1;
  localparam logic [2:0] ADDR_RES_HIGH = 3'h2;
  localparam logic [2:0] ADDR_RES_LOW  = 3'h3;
  localparam logic [2:0] ADDR_STATUS   = 3'h4;
  localparam logic [2:0] ADDR_PORT     = 3'h5;
  localparam logic [2:0] ADDR_AMASK    = 3'h6;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CTRL0_CLK_HI  = 7;
  localparam int CTRL0_CLK_LO  = 6;
  localparam int CTRL0_CHAN_HI = 5;
  localparam int CTRL0_CHAN_LO = 3;
  localparam int CTRL0_GO      = 2;
  localparam int CTRL0_ON      = 0;
  localparam int CTRL1_FMT     = 7;
  localparam int STATUS_DONE   = 0;

  // ***************************************************************
  // reset values and codes
  // ***************************************************************
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [1:0] CLK_DIV2     = 2'h0;
  localparam logic [1:0] CLK_DIV8     = 2'h1;
  localparam logic [1:0] CLK_DIV32    = 2'h2;
  localparam logic [1:0] CLK_RC       = 2'h3;
  localparam logic [9:0] SAR_MSB      = 10'h200;
  localparam logic [5:0] PAD_ZERO     = 6'h00;

  // ***************************************************************
  // timing: clock 25 MHz, instruction cycle of four oscillator periods
  // ***************************************************************
  localparam int CLK_NS      = 40;
  localparam int TCY_OSC     = 4;
  localparam int TCY_CYC     = TCY_OSC;
  localparam int RC_TAD_NS   = 4000;
  localparam int DIV2_CYC    = 2;
  localparam int DIV8_CYC    = 8;
  localparam int DIV32_CYC   = 32;
  localparam int CONV_TADS   = 11;
  localparam int HOLDOFF_TADS = 2;
  localparam int RES_BITS    = 10;

  typedef enum logic [2:0] {
    ST_OFF, ST_ACQ, ST_FIRST, ST_CONV, ST_HOLDOFF, ST_PDOWN
  } acs_state_e;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acs_req_s;

endpackage

/* File: verilog/acs_tick.sv */
`timescale 1ns/1ps

// ***************************************************************
// bit period tick: one pulse every 'period' clocks while run holds
// ***************************************************************
module acs_tick #(
  parameter int TW = 8
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // control
  input  wire logic          run,
  input  wire logic [TW-1:0] period,
  // tick out
  output logic               tick
);

  logic [TW-1:0] cnt;

  // counter restarts whenever run drops, so every segment opens a full period
  always_ff @(posedge mclk) begin
    if (sys_rst || !run) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt >= period - TW'(1)) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + TW'(1);
      tick <= 1'b0;
    end
  end

endmodule

/* File: tb/acs_analog.sv */
`timescale 1ns/1ps

// ***************************************************************
// analog side: sample-hold capacitor and comparator
// ***************************************************************
module acs_analog
  import acs_pkg::*;
(
  // clock
  input  wire logic            mclk,
  // input levels, index is the channel code
  input  wire logic [7:0][9:0] level,
  // converter side
  input  wire logic [2:0]      channel_select,
  input  wire logic            hold_connect,
  input  wire logic            analog_powered,
  input  wire logic [9:0]      trial,
  output logic                 cmp_high
);
  logic [9:0] held = 10'h000;
  logic       junk = 1'b0;

  // capacitor follows the channel only while connected; pin setup plays no part
  always_ff @(posedge mclk) begin
    if (hold_connect) begin
      held <= level[channel_select];
    end
  end

  // an unpowered comparator gives nothing usable, so it toggles instead of holding
  always_ff @(posedge mclk) begin
    junk <= ~junk;
  end

  assign cmp_high = analog_powered ? (held >= trial) : junk;
endmodule

/* File: tb/adc_conversion_sequencer_test.sv */
`timescale 1ns/1ps

module adc_conversion_sequencer_test;
  import acs_pkg::*;

  // ***************************************************************
  // setup
  // ***************************************************************
  localparam int ACQ   = 500;   // clocks, longer than the 19.72 us acquisition
  localparam int LIMIT = 40000;
  localparam logic [7:0][9:0] LVL = {10'h333, 10'h001, 10'h1FF, 10'h200,
                                     10'h15A, 10'h2A5, 10'h000, 10'h3FF};
  logic       mclk, sys_rst, sleep, irq_enable, wake, done_flag, cmp_high;
  logic       hold_connect, analog_powered, wake_seen;
  acs_req_s   req;
  logic [7:0] rdata, port_pins, d, kh, kl;
  logic [9:0] trial;
  logic [2:0] channel_select;
  int         err_total, samples_checked, cyc;

  acs_seq i_acs_seq (.mclk(mclk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .sleep(sleep), .irq_enable(irq_enable), .port_pins(port_pins), .wake(wake),
    .done_flag(done_flag), .cmp_high(cmp_high), .trial(trial),
    .channel_select(channel_select), .hold_connect(hold_connect),
    .analog_powered(analog_powered));

  acs_analog i_acs_analog (.mclk(mclk), .level(LVL), .channel_select(channel_select),
    .hold_connect(hold_connect), .analog_powered(analog_powered), .trial(trial),
    .cmp_high(cmp_high));

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask

  function automatic int per(input logic [1:0] c);
    case (c)
      CLK_DIV2:  return DIV2_CYC;
      CLK_DIV8:  return DIV8_CYC;
      CLK_DIV32: return DIV32_CYC;
      default:   return RC_TAD_NS / CLK_NS;
    endcase
  endfunction

  function automatic logic [15:0] just(input logic [9:0] v, input logic f);
    return f ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_off;
    reg_rd(ADDR_CTRL0, d);
    chk(16'(d), 16'h0000);
    reg_rd(ADDR_STATUS, d);
    chk(16'(d), 16'h0000);
    reg_wr(ADDR_RES_HIGH, 8'hA5);
    reg_wr(ADDR_RES_LOW, 8'h5A);
    reg_rd(ADDR_RES_HIGH, kh);
    reg_rd(ADDR_RES_LOW, kl);
    chk({kh, kl}, 16'hA55A);
    reg_wr(ADDR_CTRL0, 8'h04);
    repeat (300) @(posedge mclk);
    reg_rd(ADDR_CTRL0, d);
    chk(16'(d), 16'h0000);
    chk(16'({analog_powered, done_flag}), 16'h0000);
    reg_rd(3'h7, d);
    chk(16'(d), 16'h0000);
    $display("done converter off");
  endtask

  task automatic t_port;
    port_pins <= 8'hFF;
    reg_wr(ADDR_AMASK, 8'h0F);
    reg_rd(ADDR_PORT, d);
    chk(16'(d), 16'h00F0);
    port_pins <= 8'h5A;
    reg_wr(ADDR_AMASK, 8'hC3);
    reg_rd(ADDR_PORT, d);
    chk(16'(d), 16'h0018);
    $display("done port read");
  endtask

  // channel code also picks the clock (low bits) and the format (top bit)
  task automatic t_convert(input logic [2:0] ch);
    int n, m, p;
    p = per(ch[1:0]);
    reg_wr(ADDR_CTRL1, {ch[2], 7'h00});
    reg_wr(ADDR_CTRL0, {ch[1:0], ch, 3'b001}); // on first, go later
    repeat (ACQ) @(posedge mclk); // acquisition before go
    chk(16'(channel_select), 16'(ch));
    reg_wr(ADDR_STATUS, 8'h01);
    reg_wr(ADDR_CTRL0, {ch[1:0], ch, 3'b101});
    wait_hi(done_flag, n);
    chk(16'(n >= 12 * p && n <= 13 * p + 12), 16'h0001);
    wait_hi(hold_connect, m);
    chk(16'(m >= 2 * p - 1 && m <= 2 * p + 4), 16'h0001);
    reg_rd(ADDR_RES_HIGH, kh);
    reg_rd(ADDR_RES_LOW, kl);
    chk({kh, kl}, just(LVL[ch], ch[2]));
    reg_rd(ADDR_CTRL0, d);
    chk(16'(d), 16'({ch[1:0], ch, 3'b001}));
    reg_rd(ADDR_STATUS, d);
    chk(16'(d[0]), 16'h0001);
    $display("done conversion channel %0d", ch);
  endtask

  task automatic t_abort;
    int m;
    logic [7:0] h;
    reg_wr(ADDR_CTRL0, {CLK_DIV8, 3'h1, 3'b001});
    repeat (ACQ) @(posedge mclk);
    reg_rd(ADDR_RES_HIGH, kh);
    reg_rd(ADDR_RES_LOW, kl);
    reg_wr(ADDR_STATUS, 8'h01);
    reg_rd(ADDR_STATUS, d);
    chk(16'(d), 16'h0000);
    reg_wr(ADDR_CTRL0, {CLK_DIV8, 3'h1, 3'b101});
    repeat (30) @(posedge mclk);
    chk(16'(hold_connect), 16'h0000);
    reg_wr(ADDR_CTRL0, {CLK_DIV8, 3'h1, 3'b001});
    wait_hi(hold_connect, m);
    chk(16'(m >= 2 * DIV8_CYC - 1 && m <= 2 * DIV8_CYC + 4), 16'h0001);
    reg_rd(ADDR_RES_HIGH, h);
    reg_rd(ADDR_RES_LOW, d);
    chk({h, d}, {kh, kl});
    reg_rd(ADDR_STATUS, d);
    chk(16'(d[0]), 16'h0000);
    $display("done abort");
  endtask

  // rc clock is the one choice that keeps converting in sleep
  task automatic t_sleep(input logic irq);
    int n;
    wake_seen = 1'b0;
    irq_enable <= irq;
    reg_wr(ADDR_CTRL1, 8'h80);
    // rc period of about 4 us stays above the 1.6 us floor at any clock rate
    reg_wr(ADDR_CTRL0, {CLK_RC, 3'h2, 3'b001});
    repeat (ACQ) @(posedge mclk);
    reg_wr(ADDR_STATUS, 8'h01);
    reg_wr(ADDR_CTRL0, {CLK_RC, 3'h2, 3'b101});
    sleep <= 1'b1; // sleep straight after go
    wait_hi(done_flag, n);
    chk(16'(n >= 12 * per(CLK_RC) && n <= 13 * per(CLK_RC) + 12), 16'h0001);
    repeat (4) @(posedge mclk);
    chk(16'(wake_seen), 16'(irq));
    reg_rd(ADDR_CTRL0, d);
    chk(16'(d), 16'({CLK_RC, 3'h2, 3'b001}));
    reg_rd(ADDR_RES_HIGH, kh);
    reg_rd(ADDR_RES_LOW, kl);
    chk({kh, kl}, just(LVL[2], 1'b1));
    if (!irq) begin
      repeat (2 * per(CLK_RC) + 8) @(posedge mclk);
      chk(16'(analog_powered), 16'h0000);
    end
    sleep <= 1'b0;
    repeat (10) @(posedge mclk);
    $display("done sleep conversion irq %0d", irq);
  endtask

  task automatic t_sleep_abort;
    logic [7:0] h;
    reg_wr(ADDR_CTRL0, {CLK_DIV8, 3'h3, 3'b001});
    repeat (ACQ) @(posedge mclk);
    reg_rd(ADDR_RES_HIGH, kh);
    reg_rd(ADDR_RES_LOW, kl);
    reg_wr(ADDR_STATUS, 8'h01);
    reg_wr(ADDR_CTRL0, {CLK_DIV8, 3'h3, 3'b101});
    repeat (20) @(posedge mclk);
    sleep <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(16'(analog_powered), 16'h0000);
    reg_rd(ADDR_CTRL0, d);
    chk(16'(d), 16'({CLK_DIV8, 3'h3, 3'b001}));
    reg_rd(ADDR_RES_HIGH, h);
    reg_rd(ADDR_RES_LOW, d);
    chk({h, d}, {kh, kl});
    reg_rd(ADDR_STATUS, d);
    chk(16'(d[0]), 16'h0000);
    sleep <= 1'b0;
    repeat (40) @(posedge mclk);
    $display("done sleep abort");
  endtask

  // ***************************************************************
  // clock, watchdog and main sequence
  // ***************************************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // wake is a one-cycle pulse, so catch it whenever it comes
  always @(posedge mclk) begin
    if (wake === 1'b1) begin
      wake_seen = 1'b1;
    end
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      $display("BAD %0t run did not finish in time", $time);
      give_verdict;
    end
  end

  initial begin
    req = '0;
    sleep = 1'b0;
    irq_enable = 1'b0;
    port_pins = 8'h00;
    sys_rst = 1'b1;
    cyc = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    t_off;
    t_port;
    for (int i = 0; i < 8; i++) begin
      t_convert(3'(i));
    end
    t_abort;
    t_sleep(1'b1);
    t_sleep(1'b0);
    t_sleep_abort;
    give_verdict;
  end
endmodule
